// ===== rtl/ext_bus_port.sv
// external bus port: master sequencer, slave access path, pin drivers
`timescale 1ns/1ps
module ext_bus_port #(
  parameter int FIFO_DEPTH = ext_bus_pkg::FIFO_DEPTH,
  parameter int SLAVE_WAIT = 2
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // configuration
  input wire logic [2:0] processor_identifier_i,
  input wire logic sync_mode_i,
  input wire logic [4:0] bank_shift_i,
  input wire logic bus_master_i,
  // core request side
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic req_high_i,
  input wire logic req_low_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [63:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic [63:0] rsp_rdata_o,
  // internal memory side for slave accesses
  output logic slv_valid_o,
  output logic slv_write_o,
  output logic [1:0] slv_word_o,
  output logic [31:0] slv_addr_o,
  output logic [63:0] slv_wdata_o,
  input wire logic [63:0] slv_rdata_i,
  // address pins
  input wire logic [31:0] ext_addr_bus_i,
  output logic [31:0] ext_addr_bus_o,
  output logic ext_addr_bus_oe_o,
  // data pins
  input wire logic [63:0] ext_data_bus_i,
  output logic [63:0] ext_data_bus_o,
  output logic ext_data_bus_oe_o,
  // bank selects
  output logic [3:0] bank_select_n_o,
  output logic bank_select_oe_o,
  // strobes
  input wire logic read_low_word_n_i,
  input wire logic read_high_word_n_i,
  input wire logic write_low_word_n_i,
  input wire logic write_high_word_n_i,
  output logic read_low_word_n_o,
  output logic read_high_word_n_o,
  output logic write_low_word_n_o,
  output logic write_high_word_n_o,
  output logic strobe_oe_o,
  // acknowledge and suspend
  input wire logic ack_i,
  output logic ack_o,
  output logic ack_oe_o,
  input wire logic suspend_bus_tristate_n_i
);
  localparam int RW = ext_bus_pkg::REQ_W;
  localparam int AW = ext_bus_pkg::ADDR_W;
  localparam int DW = ext_bus_pkg::DATA_W;

  ext_bus_pkg::mst_state_t st_q, st_d;
  logic f_valid, f_ready;
  logic [RW-1:0] f_data;
  logic [RW-1:0] cur_q, cur_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [DW-1:0] dout_q, dout_d;
  logic [3:0] sel_q, sel_d;
  logic [3:0] strb_q, strb_d;
  logic aoe_q, aoe_d, doe_q, doe_d, soe_q, soe_d;
  logic rsp_v_q, rsp_v_d;
  logic [DW-1:0] rsp_q, rsp_d;
  logic susp_n;
  logic keep_en;
  logic keep_drv;
  logic [DW-1:0] kept_q, kept_d;
  logic [AW-1:0] saddr_q, saddr_d;
  logic [3:0] sstrb_q, sstrb_d;
  logic [7:0] swait_q, swait_d;
  logic sv_q, sv_d, ack_q, ack_d, ackoe_q, ackoe_d;
  logic sdoe_q, sdoe_d;
  logic [DW-1:0] sdout_q, sdout_d;
  logic [3:0] pin_strb;
  logic wr, hi, lo;

  // core requests queue here so bursts of requests stall the core, not drop
  req_fifo #(.WIDTH(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .in_valid_i(req_valid_i),
    .in_ready_o(req_ready_o),
    .in_data_i({req_write_i, req_high_i, req_low_i, req_addr_i, req_wdata_i}),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );

  // suspend may arrive at any time, so it is synchronised [R19]
  sync2 #(.RST_VAL(1'b1)) u_susp (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .async_i(suspend_bus_tristate_n_i),
    .sync_o(susp_n)
  );

  assign wr = cur_q[RW-1];
  assign hi = cur_q[RW-2];
  assign lo = cur_q[RW-3];
  // strobe inputs sampled directly: they are synchronous to the clock [R19]
  assign pin_strb = {read_low_word_n_i, read_high_word_n_i,
                     write_low_word_n_i, write_high_word_n_i};
  assign keep_en = (processor_identifier_i[2:1] == ext_bus_pkg::KEEPER_ID[2:1]);
  // keeper holds the pins only while no strobe is active; during a transfer
  // some party drives the data lines and the keeper must not fight it [R5]
  assign keep_drv = keep_en && (pin_strb == 4'hf);

  // master sequencer: address phase, strobe phase, wait for ack
  always_comb begin
    st_d = st_q;
    cur_d = cur_q;
    addr_d = addr_q;
    dout_d = dout_q;
    sel_d = sel_q;
    strb_d = strb_q;
    aoe_d = aoe_q;
    doe_d = doe_q;
    soe_d = soe_q;
    rsp_v_d = 1'b0;
    rsp_d = rsp_q;
    f_ready = 1'b0;
    case (st_q)
      ext_bus_pkg::ST_IDLE: begin
        strb_d = 4'hf; // [R22]
        sel_d = ext_bus_pkg::SEL_IDLE;
        aoe_d = 1'b0;
        doe_d = 1'b0;
        soe_d = 1'b0;
        // a suspended or non-master port starts nothing [R17]
        if (f_valid && bus_master_i && susp_n) begin
          f_ready = 1'b1;
          cur_d = f_data;
          addr_d = f_data[AW+DW-1:DW]; // [R1] [R3]
          dout_d = f_data[DW-1:0];
          // selects move with the address in both modes [R6] [R7] [R8]
          sel_d = ext_bus_pkg::bank_decode(f_data[AW+DW-1:DW], bank_shift_i);
          aoe_d = 1'b1;
          soe_d = 1'b1;
          st_d = ext_bus_pkg::ST_ADDR;
        end
      end
      ext_bus_pkg::ST_ADDR: begin
        strb_d = {~(lo & ~wr), ~(hi & ~wr), ~(lo & wr), ~(hi & wr)}; // [R9] [R11] [R13] [R15]
        doe_d = wr; // [R4]
        st_d = ext_bus_pkg::ST_STRB;
      end
      ext_bus_pkg::ST_STRB: begin
        // hold while the target stretches with ack low [R20]
        if (ack_i) begin
          if (sync_mode_i) begin
            sel_d = ext_bus_pkg::SEL_IDLE; // [R8]
          end
          strb_d = 4'hf; // [R22]
          rsp_d = ext_data_bus_i;
          rsp_v_d = ~wr;
          st_d = ext_bus_pkg::ST_DONE;
        end
      end
      ext_bus_pkg::ST_DONE: begin
        // write data stays one cycle past the strobe so the target sees it settled
        sel_d = ext_bus_pkg::SEL_IDLE; // [R7]
        doe_d = 1'b0;
        st_d = ext_bus_pkg::ST_IDLE;
      end
      default: begin
        st_d = ext_bus_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      st_q <= ext_bus_pkg::ST_IDLE;
      cur_q <= '0;
      addr_q <= '0;
      dout_q <= '0;
      sel_q <= ext_bus_pkg::SEL_IDLE;
      strb_q <= 4'hf;
      aoe_q <= 1'b0;
      doe_q <= 1'b0;
      soe_q <= 1'b0;
      rsp_v_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      st_q <= st_d;
      cur_q <= cur_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      sel_q <= sel_d;
      strb_q <= strb_d;
      aoe_q <= aoe_d;
      doe_q <= doe_d;
      soe_q <= soe_d;
      rsp_v_q <= rsp_v_d;
      rsp_q <= rsp_d;
    end
  end

  // slave path: an outside master strobes our internal memory [R10] [R12] [R14] [R16]
  always_comb begin
    saddr_d = ext_addr_bus_i; // [R2]
    sstrb_d = bus_master_i ? 4'hf : pin_strb;
    sv_d = 1'b0;
    swait_d = swait_q;
    ack_d = 1'b1;
    ackoe_d = 1'b0;
    sdoe_d = 1'b0;
    sdout_d = sdout_q;
    if (!bus_master_i && sstrb_q != 4'hf) begin
      ackoe_d = sync_mode_i;
      if (swait_q < 8'(SLAVE_WAIT)) begin
        swait_d = swait_q + 8'h01;
        ack_d = 1'b0; // [R21]
      end else if (swait_q == 8'(SLAVE_WAIT)) begin
        // count one past the limit so a held strobe is passed inward only once;
        // a strobe that changes at this point is dropped, not half served
        swait_d = swait_q + 8'h01;
        sv_d = (sstrb_d == sstrb_q);
      end
      sdoe_d = ~(sstrb_q[3] & sstrb_q[2]); // read: we answer on the data pins
      sdout_d = slv_rdata_i;
    end else begin
      swait_d = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      saddr_q <= '0;
      sstrb_q <= 4'hf;
      sv_q <= 1'b0;
      swait_q <= '0;
      ack_q <= 1'b1;
      ackoe_q <= 1'b0;
      sdoe_q <= 1'b0;
      sdout_q <= '0;
    end else begin
      saddr_q <= saddr_d;
      sstrb_q <= sstrb_d;
      sv_q <= sv_d;
      swait_q <= swait_d;
      ack_q <= ack_d;
      ackoe_q <= ackoe_d;
      sdoe_q <= sdoe_d;
      sdout_q <= sdout_d;
    end
  end

  // keeper: remember the last level that any party drove on the bus [R5]
  always_comb begin
    kept_d = kept_q;
    if (doe_q) begin
      kept_d = dout_q;
    end else if (sdoe_q) begin
      kept_d = sdout_q;
    end else if (pin_strb != 4'hf) begin
      // another party drives during its strobe; idle levels are not taken
      kept_d = ext_data_bus_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      kept_q <= '0;
    end else begin
      kept_q <= kept_d;
    end
  end

  // pin drivers; suspend or slave role floats master outputs [R18] [R17]
  assign ext_addr_bus_o = addr_q;
  assign ext_addr_bus_oe_o = aoe_q & susp_n & bus_master_i; // [R18]
  assign ext_data_bus_o = doe_q ? dout_q : (sdoe_q ? sdout_q : kept_q);
  assign ext_data_bus_oe_o = ((doe_q & bus_master_i) | sdoe_q | keep_drv) & susp_n; // [R4] [R5]
  assign bank_select_n_o = sel_q;
  assign bank_select_oe_o = soe_q & susp_n & bus_master_i;
  assign {read_low_word_n_o, read_high_word_n_o, write_low_word_n_o, write_high_word_n_o} = strb_q;
  assign strobe_oe_o = soe_q & susp_n & bus_master_i; // [R17] [R18]
  assign ack_o = ack_q;
  assign ack_oe_o = ackoe_q;
  assign rsp_valid_o = rsp_v_q;
  assign rsp_rdata_o = rsp_q;
  assign slv_valid_o = sv_q;
  assign slv_write_o = ~(sstrb_q[1] & sstrb_q[0]);
  assign slv_word_o = {~(sstrb_q[2] & sstrb_q[0]), ~(sstrb_q[3] & sstrb_q[1])};
  assign slv_addr_o = saddr_q;
  assign slv_wdata_o = ext_data_bus_i;
endmodule : ext_bus_port

// ===== inc/ext_bus_pkg.sv
// constants and types for the external bus port
// Notes on behaviour
// [R1] master drives address of each external access
// [R2] slave takes address from bus as input
// [R3] master drives address for peer internal access
// [R4] data bus carries words both ways
// [R5] keeper holds last data when undriven
// [R6] bank select decoded from address, one low
// [R7] async mode: selects change with address
// [R8] sync mode: select drops after ack seen
// [R9] read low strobe for low word reads
// [R10] outside party asserts read low to read
// [R11] read high strobe for high word reads
// [R12] outside party asserts read high to read
// [R13] write low strobe for low word writes
// [R14] outside party asserts write low to write
// [R15] write high strobe for high word writes
// [R16] outside party asserts write high to write
// [R17] only the bus master drives strobes
// [R18] tristate outputs on suspend or slave
// [R19] sync inputs sampled; async ones synchronised
// [R20] target pulls ack low for wait states
// [R21] device pulls ack low while slave busy; the port drives ack only when sync_mode_i is set
// [R22] strobes active low, idle high between accesses
package ext_bus_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int WORD_W = 32;
  localparam int BANKS = 4;
  localparam int FIFO_DEPTH = 16;
  // bank size exponent reset value: banks of 2**BANK_SHIFT_RST words
  localparam logic [4:0] BANK_SHIFT_RST = 5'h14;
  // bank region starts above internal space
  localparam logic [ADDR_W-1:0] EXT_BASE = 32'h0010_0000;
  localparam logic [BANKS-1:0] SEL_IDLE = 4'hf;
  localparam logic [2:0] KEEPER_ID = 3'h0;
  // request word: write flag, high flag, low flag, address, data
  localparam int REQ_W = 3 + ADDR_W + DATA_W;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_STRB = 2'b10,
    ST_DONE = 2'b11
  } mst_state_t;

  // active-low bank select from address and bank size; at most one low, none outside the four banks
  function automatic logic [BANKS-1:0] bank_decode(input logic [ADDR_W-1:0] a,
                                                  input logic [4:0] shift);
    logic [ADDR_W-1:0] off;
    logic [ADDR_W-1:0] idx;
    off = a - EXT_BASE;
    idx = off >> shift;
    bank_decode = SEL_IDLE;
    if (a >= EXT_BASE && idx < ADDR_W'(BANKS)) begin
      bank_decode[idx[1:0]] = 1'b0;
    end
  endfunction : bank_decode
endpackage : ext_bus_pkg

// ===== rtl/req_fifo.sv
// request fifo in front of the bus master sequencer
`timescale 1ns/1ps
module req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  // full when pointers differ only in the wrap bit
  assign in_ready_o = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid_o = (wr_q != rd_q);
  assign out_data_o = mem_q[rd_q[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    wr_d = wr_q + (AW+1)'(push);
    rd_d = rd_q + (AW+1)'(pop);
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage has no reset; only words behind the pointers are read
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
endmodule : req_fifo

// ===== rtl/sync2.sv
// two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;
  logic sync_q;

  // first stage is read only by the second
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule : sync2

// ===== dv/ext_bus_port_props.sv
// pin-level assertions for the external bus port
`timescale 1ns/1ps
module ext_bus_port_props #(
  parameter int FIFO_DEPTH = 16,
  parameter int SLAVE_WAIT = 2
) (
  // clock, reset, control
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic sync_mode_i,
  input wire logic bus_master_i,
  input wire logic suspend_bus_tristate_n_i,
  input wire logic read_low_word_n_i,
  input wire logic ack_i,
  // pin drivers
  input wire logic ext_addr_bus_oe_o,
  input wire logic ext_data_bus_oe_o,
  input wire logic [3:0] bank_select_n_o,
  input wire logic bank_select_oe_o,
  input wire logic read_low_word_n_o,
  input wire logic read_high_word_n_o,
  input wire logic write_low_word_n_o,
  input wire logic write_high_word_n_o,
  input wire logic strobe_oe_o,
  input wire logic ack_o,
  input wire logic ack_oe_o,
  input wire logic slv_valid_o
);
  localparam int SW_HI = SLAVE_WAIT + 2;
  logic act;
  logic wr;
  // act: we drive some strobe low; wr: it is a write
  assign act = strobe_oe_o && !(read_low_word_n_o && read_high_word_n_o && !wr);
  assign wr = !(write_low_word_n_o && write_high_word_n_o);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  a_slave_quiet: assert property (!bus_master_i |-> !strobe_oe_o && !ext_addr_bus_oe_o)
    else $error("strobes or address driven as slave");
  a_suspend_float: assert property (!suspend_bus_tristate_n_i [*3] |->
    !(ext_addr_bus_oe_o || ext_data_bus_oe_o || bank_select_oe_o || strobe_oe_o))
    else $error("outputs driven while suspended");
  a_one_bank: assert property (bank_select_oe_o |-> $onehot0(~bank_select_n_o))
    else $error("more than one bank selected");
  a_master_drive: assert property (act |-> ext_addr_bus_oe_o && (ext_data_bus_oe_o || !wr))
    else $error("address or write data not driven");
  a_wait_holds: assert property (act && !ack_i |=> act)
    else $error("strobe released during wait");
  a_strobe_release: assert property (act && ack_i |-> ##[1:2] !act)
    else $error("strobe not released after ack");
  a_sync_sel_drop: assert property (sync_mode_i && act && ack_i && bank_select_n_o != 4'hf |->
    ##[1:3] bank_select_n_o == 4'hf)
    else $error("bank select held after ack");
  a_slave_ack: assert property (sync_mode_i && !bus_master_i && $fell(read_low_word_n_i) |->
    ##[1:2] (ack_oe_o && !ack_o))
    else $error("no wait state on slave access");
  a_slave_valid: assert property (!bus_master_i && $fell(read_low_word_n_i) |->
    ##[1:SW_HI] slv_valid_o)
    else $error("slave access not passed inward");
  a_valid_once: assert property (slv_valid_o |=> !slv_valid_o [*4])
    else $error("slave access passed inward twice");
endmodule : ext_bus_port_props

bind ext_bus_port ext_bus_port_props #(.FIFO_DEPTH(FIFO_DEPTH), .SLAVE_WAIT(SLAVE_WAIT)) props (
  .clock_i, .nrst_i, .sync_mode_i, .bus_master_i, .suspend_bus_tristate_n_i, .read_low_word_n_i,
  .ack_i, .ext_addr_bus_oe_o, .ext_data_bus_oe_o, .bank_select_n_o, .bank_select_oe_o,
  .read_low_word_n_o, .read_high_word_n_o, .write_low_word_n_o, .write_high_word_n_o,
  .strobe_oe_o, .ack_o, .ack_oe_o, .slv_valid_o);

// ===== dv/ext_mem_model.sv
// behavioural external memory answering the port's strobes
`timescale 1ns/1ps
module ext_mem_model (
  // clock and bench control
  input wire logic clock_i,
  input wire logic clr_i,
  input wire logic [31:0] wait_i,
  // bus pins {rd lo, rd hi, wr lo, wr hi}
  input wire logic [3:0] sel_n_i,
  input wire logic [3:0] strb_n_i,
  input wire logic [63:0] data_i,
  output logic [63:0] data_o,
  output logic data_oe_o,
  output logic ack_o,
  // what the memory saw
  output logic [63:0] mem_o,
  output logic [3:0] seen_o,
  output logic [3:0] sel_o
);
  int cnt = 0;
  logic on;
  initial {mem_o, seen_o, sel_o} = {64'h0, 4'h0, 4'hf};
  // selected and some active-low strobe down
  assign on = !(&sel_n_i) && !(&strb_n_i);
  // ack low for wait_i cycles stretches the access
  assign ack_o = !on || cnt >= wait_i;
  // drive data only while a read strobe is held
  assign data_oe_o = on && !(strb_n_i[3] && strb_n_i[2]);
  assign data_o = mem_o;
  // store written words, note strobes and selects used
  always @(posedge clock_i) begin
    cnt <= on ? cnt + 1 : 0;
    if (on && !strb_n_i[1]) mem_o[31:0] <= data_i[31:0];
    if (on && !strb_n_i[0]) mem_o[63:32] <= data_i[63:32];
    if (clr_i) seen_o <= 4'h0;
    else if (on) seen_o <= seen_o | ~strb_n_i;
    if (on) sel_o <= sel_n_i;
  end
endmodule : ext_mem_model

// ===== dv/external_bus_port_strobes_test.sv
// self-checking bench for the external bus port
`timescale 1ns/1ps
module external_bus_port_strobes_test;
  logic clock_i = 0, nrst_i = 0, sync_mode_i = 0, bus_master_i = 0;
  logic suspend_bus_tristate_n_i = 1, tb_doe = 0, m_clr = 0;
  logic req_valid_i = 0, req_write_i = 0, req_high_i = 0, req_low_i = 0;
  logic [2:0] processor_identifier_i = 3'h0;
  logic [4:0] bank_shift_i = 5'h04;
  logic [31:0] req_addr_i = 32'h0, tb_addr = 32'h0, m_wait = 32'h0;
  logic [31:0] ext_addr_bus_i, ext_addr_bus_o, slv_addr_o;
  logic [63:0] req_wdata_i = 64'h0, slv_rdata_i = 64'h0, tb_d = 64'h0, last_d = 64'h0;
  logic [63:0] rsp_rdata_o, slv_wdata_o, ext_data_bus_i, ext_data_bus_o, m_d, m_mem, d;
  logic [3:0] tb_strb = 4'hf, bank_select_n_o, strb_in, strb_out, m_seen, m_sel;
  logic req_ready_o, rsp_valid_o, slv_valid_o, slv_write_o, ext_addr_bus_oe_o, m_oe, m_ack;
  logic ext_data_bus_oe_o, bank_select_oe_o, strobe_oe_o, ack_o, ack_oe_o, ack_i;
  logic read_low_word_n_i, read_high_word_n_i, write_low_word_n_i, write_high_word_n_i;
  logic read_low_word_n_o, read_high_word_n_o, write_low_word_n_o, write_high_word_n_o;
  logic [1:0] slv_word_o;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  localparam logic [31:0] A1 = 32'h0010_0010;
  localparam logic [63:0] WD = 64'h89ab_cdef_0123_4567;
  always #5 clock_i = ~clock_i;
  // pin levels: driver wins; undriven data toggles so stale data never matches
  assign strb_out = {read_low_word_n_o, read_high_word_n_o, write_low_word_n_o,
    write_high_word_n_o};
  assign strb_in = strobe_oe_o ? strb_out : tb_strb;
  assign {read_low_word_n_i, read_high_word_n_i, write_low_word_n_i, write_high_word_n_i} = strb_in;
  assign ext_addr_bus_i = ext_addr_bus_oe_o ? ext_addr_bus_o : tb_addr;
  assign ext_data_bus_i = ext_data_bus_oe_o ? ext_data_bus_o : m_oe ? m_d : tb_doe ? tb_d : ~last_d;
  assign ack_i = ack_oe_o ? ack_o : m_ack;
  always @(posedge clock_i) last_d <= ext_data_bus_i;
  ext_bus_port dut (.clock_i, .nrst_i, .processor_identifier_i, .sync_mode_i, .bank_shift_i,
    .bus_master_i, .req_valid_i, .req_ready_o, .req_write_i, .req_high_i, .req_low_i, .req_addr_i,
    .req_wdata_i, .rsp_valid_o, .rsp_rdata_o, .slv_valid_o, .slv_write_o, .slv_word_o, .slv_addr_o,
    .slv_wdata_o, .slv_rdata_i, .ext_addr_bus_i, .ext_addr_bus_o, .ext_addr_bus_oe_o,
    .ext_data_bus_i, .ext_data_bus_o, .ext_data_bus_oe_o, .bank_select_n_o, .bank_select_oe_o,
    .read_low_word_n_i, .read_high_word_n_i, .write_low_word_n_i, .write_high_word_n_i,
    .read_low_word_n_o, .read_high_word_n_o, .write_low_word_n_o, .write_high_word_n_o,
    .strobe_oe_o, .ack_i, .ack_o, .ack_oe_o, .suspend_bus_tristate_n_i);
  ext_mem_model mdl (.clock_i, .clr_i(m_clr), .wait_i(m_wait), .strb_n_i(strb_in),
    .sel_n_i(bank_select_oe_o ? bank_select_n_o : 4'hf), .data_i(ext_data_bus_i), .data_o(m_d),
    .data_oe_o(m_oe), .ack_o(m_ack), .mem_o(m_mem), .seen_o(m_seen), .sel_o(m_sel));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  // one request, held until an edge sees ready
  task automatic push(input logic [2:0] kind, input logic [31:0] a, input logic [63:0] wd);
    int n;
    n = 0;
    @(negedge clock_i);
    {req_write_i, req_high_i, req_low_i} = kind;
    req_addr_i = a;
    req_wdata_i = wd;
    req_valid_i = 1;
    while (!req_ready_o && n < 50) begin
      @(negedge clock_i);
      n++;
    end
    @(negedge clock_i);
    req_valid_i = 0;
  endtask : push
  task automatic get_rsp;
    int n;
    n = 0;
    while (!rsp_valid_o && n < 100) begin
      @(negedge clock_i);
      n++;
    end
    chk(rsp_valid_o, 1, "read response");
    d = rsp_rdata_o;
    @(negedge clock_i);
  endtask : get_rsp
  task automatic t_write;
    int n;
    n = 0;
    push(3'b111, A1, WD);
    while (!(m_seen != 0 && &strb_in) && n < 100) begin
      @(negedge clock_i);
      n++;
    end
    chk(m_mem, WD, "written words");
    chk(m_seen, 4'h3, "write strobes");
    chk(m_sel, 4'hd, "bank select");
    chk(ext_addr_bus_o, A1, "address");
    $display("test write done");
  endtask : t_write
  task automatic t_reads;
    m_clr = 1;
    m_wait = 32'h3;
    push(3'b001, A1, 64'h0);
    m_clr = 0;
    get_rsp;
    chk(d[31:0], WD[31:0], "low word read");
    chk(m_seen, 4'h8, "low read strobe only");
    m_clr = 1;
    sync_mode_i = 1;
    m_wait = 32'h1;
    push(3'b011, A1, 64'h0);
    m_clr = 0;
    get_rsp;
    chk(d, WD, "sync read");
    chk(m_seen, 4'hc, "both read strobes");
    sync_mode_i = 0;
    $display("test reads done");
  endtask : t_reads
  task automatic t_fifo;
    bus_master_i = 0;
    m_wait = 32'h2;
    repeat (16) push(3'b001, A1, 64'h0);
    chk(req_ready_o, 0, "fifo full");
    bus_master_i = 1;
    repeat (16) begin
      get_rsp;
      chk(d[31:0], WD[31:0], "drained read");
    end
    $display("test fifo done");
  endtask : t_fifo
  task automatic t_slave;
    int n;
    bus_master_i = 0;
    sync_mode_i = 1;
    slv_rdata_i = 64'h1357_9bdf_2468_ace0;
    for (int k = 0; k < 4; k++) begin
      n = 0;
      @(negedge clock_i);
      tb_addr = 32'h0000_1000 + k;
      tb_doe = k > 1;
      tb_d = WD;
      tb_strb = ~(4'h8 >> k);
      while (!slv_valid_o && n < 20) begin
        @(negedge clock_i);
        n++;
      end
      chk(slv_addr_o, tb_addr, "slave address");
      chk(slv_word_o, k[0] ? 2'b10 : 2'b01, "slave word");
      chk(slv_write_o, k > 1, "slave write");
      if (k == 0) chk(ext_data_bus_o[31:0], slv_rdata_i[31:0], "slave read data");
      if (k == 0) chk(ext_data_bus_oe_o, 1, "slave read drive");
      if (k > 1) chk(slv_wdata_o, WD, "slave write data");
      tb_strb = 4'hf;
      tb_doe = 0;
      repeat (3) @(negedge clock_i);
    end
    sync_mode_i = 0;
    $display("test slave done");
  endtask : t_slave
  task automatic t_suspend;
    bus_master_i = 1;
    processor_identifier_i = 3'h1;
    @(negedge clock_i);
    chk(ext_data_bus_oe_o, 1, "keeper drive idle");
    chk(ext_data_bus_o, WD, "kept level");
    suspend_bus_tristate_n_i = 0;
    repeat (4) @(negedge clock_i);
    chk({ext_addr_bus_oe_o, ext_data_bus_oe_o, bank_select_oe_o, strobe_oe_o}, 4'h0, "float");
    suspend_bus_tristate_n_i = 1;
    $display("test suspend done");
  endtask : t_suspend
  // cut a hang short
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(negedge clock_i);
    chk(strb_out, 4'hf, "strobes idle");
    chk(bank_select_n_o, 4'hf, "selects idle");
    chk(ext_data_bus_oe_o, 1, "keeper drive");
    repeat (7) @(negedge clock_i);
    nrst_i = 1;
    processor_identifier_i = 3'h2;
    bus_master_i = 1;
    t_write();
    t_reads();
    t_fifo();
    t_slave();
    t_suspend();
    tally_and_finish();
  end
endmodule : external_bus_port_strobes_test
